// ==== smsp_consts.vh ====
// Purpose: Constants for the byte-wide serial master/slave port.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word.
// Notes: Definitions only.
`ifndef SMSP_CONSTS_VH
`define SMSP_CONSTS_VH

`define SMSP_OFS_CTRL 4'h0
`define SMSP_OFS_STAT 4'h4
`define SMSP_OFS_DATA 4'h8
`define SMSP_OFS_AUX 4'hC

`define SMSP_CTRL_RESET 8'h00
`define SMSP_STAT_RESET 8'h00
`define SMSP_AUX_RESET 8'h00
`define SMSP_DATA_RESET 8'h00

`define SMSP_CTRL_IRQ_EN 7
`define SMSP_CTRL_ENABLE 6
`define SMSP_CTRL_LSB_FIRST 5
`define SMSP_CTRL_MASTER 4
`define SMSP_CTRL_CLOCK_POLARITY 3
`define SMSP_CTRL_CLOCK_PHASE 2
`define SMSP_CTRL_RATE_HI 1
`define SMSP_CTRL_RATE_LO 0

`define SMSP_STAT_DONE 7
`define SMSP_STAT_COLL 6
`define SMSP_STAT_DOUBLE 0

`define SMSP_AUX_GIE 0
`define SMSP_AUX_SS_OUT_EN 1
`define SMSP_AUX_SS_LEVEL 2
`define SMSP_AUX_MISO_OE 3
`define SMSP_AUX_MOSI_OE 4
`define SMSP_AUX_SCK_OE 5
`define SMSP_AUX_VEC_ACK 7
`define SMSP_AUX_RW_MASK 8'h3F

`define SMSP_HALF_DIV4 7'h02
`define SMSP_HALF_DIV16 7'h08
`define SMSP_HALF_DIV64 7'h20
`define SMSP_HALF_DIV128 7'h40
`define SMSP_HALF_DIV2 7'h01
`define SMSP_HALF_DIV8 7'h04
`define SMSP_HALF_DIV32 7'h10

`define SMSP_EDGES_PER_BYTE 5'h10
`define SMSP_LAST_BIT 4'h7

`endif

// ==== smsp_port.v ====
// Purpose: Byte-wide serial port, master or slave, behind an Avalon-MM slave.
// Assumes: One 20 MHz clock; all pin inputs synchronous to it.
// Notes: Each access is answered one cycle after it is presented.
//
// Behaviour
// - Slave deselect clears bit count and receive shifter, drops partial byte.
// - Selected slave drives data out if enabled.
// - Master select pin output is plain output.
// - Master select input low forces slave role unless select output enabled.
// - Forced slave sets done flag, may interrupt.
// - Interrupt when done, enable, global enable.
// - No serial operation unless port enabled.
// - Bit order control picks lsb first.
// - Role bit selects master or slave.
// - Polarity bit sets idle clock level.
// - Phase bit picks sample or setup edge.
// - Master clock divided 4..128, doubled option.
// - Rate bits ignored in slave role.
// - Done flag sets, clears by vector or sequence.
// - Collision flag on write during transfer.
// - Status bits five to one read zero.
// - Double speed bit doubles master clock.
// - Data write starts send, read gives buffer.
// - Shift and sample on opposite edges.
// - Master shifts exactly eight bits then stops.
// - Single transmit buffer, double receive buffer.
// - Slave samples external clock with own clock.
`timescale 1ns/1ps
`include "smsp_consts.vh"

module smsp_port (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_sck,
  output reg o_sck,
  output reg o_sck_oe,
  input wire i_mosi,
  output reg o_mosi,
  output reg o_mosi_oe,
  input wire i_miso,
  output reg o_miso,
  output reg o_miso_oe,
  input wire i_ss_n,
  output reg o_ss_n,
  output reg o_ss_n_oe,
  output reg o_irq
);

  reg [7:0] serial_port_control;
  reg xfer_done_flag;
  reg write_collision_flag;
  reg double_speed;
  reg [7:0] aux_config;
  reg [7:0] rx_buffer;
  reg [7:0] shifter;
  reg [7:0] next_shifter;
  reg [7:0] rx_shift;
  reg [7:0] next_rx_shift;
  reg [3:0] bit_cnt;
  reg [4:0] edge_cnt;
  reg [6:0] div_cnt;
  reg [6:0] half_lim;
  reg busy;
  reg arm_done;
  reg arm_coll;
  reg sck_s1;
  reg sck_s2;
  reg sck_s3;
  reg ss_s1;
  reg ss_s2;
  reg mosi_s1;
  reg mosi_s2;
  reg [7:0] next_rbyte;

  wire xfer_irq_enable = serial_port_control[`SMSP_CTRL_IRQ_EN];
  wire port_enable = serial_port_control[`SMSP_CTRL_ENABLE];
  wire bit_order_lsb_first = serial_port_control[`SMSP_CTRL_LSB_FIRST];
  wire master_role_select = serial_port_control[`SMSP_CTRL_MASTER];
  wire clock_polarity = serial_port_control[`SMSP_CTRL_CLOCK_POLARITY];
  wire clock_phase = serial_port_control[`SMSP_CTRL_CLOCK_PHASE];
  wire rate_select_hi = serial_port_control[`SMSP_CTRL_RATE_HI];
  wire rate_select_lo = serial_port_control[`SMSP_CTRL_RATE_LO];
  wire global_irq_enable = aux_config[`SMSP_AUX_GIE];
  wire ss_out_en = aux_config[`SMSP_AUX_SS_OUT_EN];

  wire req = i_avs_read | i_avs_write;
  wire acc = req & ~o_avs_waitrequest;
  wire wr_acc = acc & i_avs_write & i_avs_byteenable[0];
  wire rd_acc = acc & i_avs_read;
  wire wr_ctrl = wr_acc & (i_avs_address == `SMSP_OFS_CTRL);
  wire wr_stat = wr_acc & (i_avs_address == `SMSP_OFS_STAT);
  wire wr_data = wr_acc & (i_avs_address == `SMSP_OFS_DATA);
  wire wr_aux = wr_acc & (i_avs_address == `SMSP_OFS_AUX);
  wire rd_stat = rd_acc & (i_avs_address == `SMSP_OFS_STAT);
  wire data_acc = acc & (i_avs_address == `SMSP_OFS_DATA);
  wire vec_ack = wr_aux & i_avs_writedata[`SMSP_AUX_VEC_ACK];
  wire [7:0] wbyte = i_avs_writedata[7:0];

  wire is_master = port_enable & master_role_select;
  wire is_slave = port_enable & ~master_role_select;
  wire slave_sel = is_slave & ~ss_s2;
  wire mode_fault = is_master & ~ss_out_en & ~ss_s2;
  wire collide = is_master ? busy : (slave_sel & (bit_cnt != 4'h0));

  wire s_rise = sck_s2 & ~sck_s3;
  wire s_fall = ~sck_s2 & sck_s3;
  wire s_lead = clock_polarity ? s_fall : s_rise;
  wire s_trail = clock_polarity ? s_rise : s_fall;

  wire m_tick = busy & (div_cnt == half_lim - 7'h01);
  wire [4:0] m_edge = edge_cnt + 5'h01;
  wire m_lead = m_tick & m_edge[0];
  wire m_trail = m_tick & ~m_edge[0];
  wire m_last = m_tick & (m_edge == `SMSP_EDGES_PER_BYTE);

  wire lead_ev = is_master ? m_lead : (slave_sel & s_lead);
  wire trail_ev = is_master ? m_trail : (slave_sel & s_trail);
  wire sample_ev = clock_phase ? trail_ev : lead_ev;
  wire setup_raw = clock_phase ? lead_ev : trail_ev;
  wire setup_ev = setup_raw & ~(clock_phase & (bit_cnt == 4'h0));
  wire in_bit = is_master ? i_miso : mosi_s2;
  wire slave_last = is_slave & sample_ev & (bit_cnt == `SMSP_LAST_BIT);

  always @* begin
    case ({double_speed, rate_select_hi, rate_select_lo})
      3'b000: begin
        half_lim = `SMSP_HALF_DIV4;
      end
      3'b001: begin
        half_lim = `SMSP_HALF_DIV16;
      end
      3'b010: begin
        half_lim = `SMSP_HALF_DIV64;
      end
      3'b011: begin
        half_lim = `SMSP_HALF_DIV128;
      end
      3'b100: begin
        half_lim = `SMSP_HALF_DIV2;
      end
      3'b101: begin
        half_lim = `SMSP_HALF_DIV8;
      end
      3'b110: begin
        half_lim = `SMSP_HALF_DIV32;
      end
      default: begin
        half_lim = `SMSP_HALF_DIV64;
      end
    endcase
  end

  // Read data selection; unmapped offsets read as zero.
  always @* begin
    case (i_avs_address)
      `SMSP_OFS_CTRL: begin
        next_rbyte = serial_port_control;
      end
      `SMSP_OFS_STAT: begin
        next_rbyte = {xfer_done_flag, write_collision_flag, 5'h00, double_speed};
      end
      `SMSP_OFS_DATA: begin
        next_rbyte = rx_buffer;
      end
      `SMSP_OFS_AUX: begin
        next_rbyte = aux_config;
      end
      default: begin
        next_rbyte = 8'h00;
      end
    endcase
  end

  always @* begin
    next_rx_shift = rx_shift;
    if (sample_ev) begin
      if (bit_order_lsb_first) begin
        next_rx_shift = {in_bit, rx_shift[7:1]};
      end else begin
        next_rx_shift = {rx_shift[6:0], in_bit};
      end
    end
    next_shifter = shifter;
    if (wr_data & ~collide) begin
      next_shifter = wbyte;
    end else if (setup_ev) begin
      if (bit_order_lsb_first) begin
        next_shifter = {1'b0, shifter[7:1]};
      end else begin
        next_shifter = {shifter[6:0], 1'b0};
      end
    end
  end

  // Avalon-MM slave: each request is answered one cycle after it appears.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      if (req & o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= {24'h000000, next_rbyte};
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
    end
  end

  // Two-stage synchronisers for the slave-side pins.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sck_s1 <= i_sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      ss_s1 <= i_ss_n;
      ss_s2 <= ss_s1;
      mosi_s1 <= i_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  // Control, status and configuration registers.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      serial_port_control <= `SMSP_CTRL_RESET;
      double_speed <= 1'b0;
      aux_config <= `SMSP_AUX_RESET;
    end else begin
      if (wr_ctrl) begin
        serial_port_control <= wbyte;
      end else if (mode_fault) begin
        serial_port_control[`SMSP_CTRL_MASTER] <= 1'b0;
      end
      if (wr_stat) begin
        double_speed <= wbyte[`SMSP_STAT_DOUBLE];
      end
      if (wr_aux) begin
        aux_config <= wbyte & `SMSP_AUX_RW_MASK;
      end
    end
  end

  // Status flags; a hardware set always wins over a clear.
  // The clear sequence is armed by the status value that the read returned.
  // A collision flag set after the read is never cleared unseen; a done flag is, if the collision flag was armed.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      arm_done <= 1'b0;
      arm_coll <= 1'b0;
    end else begin
      if (rd_stat) begin
        arm_done <= o_avs_readdata[`SMSP_STAT_DONE];
        arm_coll <= o_avs_readdata[`SMSP_STAT_COLL];
      end else if (data_acc) begin
        arm_done <= 1'b0;
        arm_coll <= 1'b0;
      end
      if (m_last | slave_last | mode_fault) begin
        xfer_done_flag <= 1'b1;
      end else if ((data_acc & (arm_done | arm_coll)) | vec_ack) begin
        xfer_done_flag <= 1'b0;
      end
      if (wr_data & collide) begin
        write_collision_flag <= 1'b1;
      end else if (data_acc & arm_coll) begin
        write_collision_flag <= 1'b0;
      end
    end
  end

  // Serial engine shared by both roles.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy <= 1'b0;
      div_cnt <= 7'h00;
      edge_cnt <= 5'h00;
      bit_cnt <= 4'h0;
      shifter <= `SMSP_DATA_RESET;
      rx_shift <= `SMSP_DATA_RESET;
      rx_buffer <= `SMSP_DATA_RESET;
      o_sck <= 1'b0;
    end else begin
      shifter <= next_shifter;
      rx_shift <= next_rx_shift;
      if (sample_ev) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (!port_enable || mode_fault) begin
        busy <= 1'b0;
        bit_cnt <= 4'h0;
        o_sck <= clock_polarity;
      end else if (is_master) begin
        if (wr_data & ~collide) begin
          busy <= 1'b1;
          div_cnt <= 7'h00;
          edge_cnt <= 5'h00;
          bit_cnt <= 4'h0;
        end else if (busy) begin
          if (m_tick) begin
            div_cnt <= 7'h00;
            edge_cnt <= m_edge;
            o_sck <= ~o_sck;
          end else begin
            div_cnt <= div_cnt + 7'h01;
          end
          if (m_last) begin
            busy <= 1'b0;
            bit_cnt <= 4'h0;
            rx_buffer <= next_rx_shift;
          end
        end else begin
          o_sck <= clock_polarity;
        end
      end else begin
        busy <= 1'b0;
        o_sck <= clock_polarity;
        if (ss_s2) begin
          bit_cnt <= 4'h0;
          rx_shift <= 8'h00;
        end else if (slave_last) begin
          bit_cnt <= 4'h0;
          rx_buffer <= next_rx_shift;
        end
      end
    end
  end

  // Pin drivers and interrupt, all registered.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mosi <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
      o_sck_oe <= 1'b0;
      o_ss_n <= 1'b1;
      o_ss_n_oe <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_mosi <= bit_order_lsb_first ? next_shifter[0] : next_shifter[7];
      o_miso <= bit_order_lsb_first ? next_shifter[0] : next_shifter[7];
      o_mosi_oe <= is_master & ~mode_fault & aux_config[`SMSP_AUX_MOSI_OE];
      o_sck_oe <= is_master & ~mode_fault & aux_config[`SMSP_AUX_SCK_OE];
      o_miso_oe <= slave_sel & aux_config[`SMSP_AUX_MISO_OE];
      o_ss_n_oe <= master_role_select & ss_out_en;
      o_ss_n <= aux_config[`SMSP_AUX_SS_LEVEL];
      o_irq <= xfer_done_flag & xfer_irq_enable & global_irq_enable;
    end
  end

endmodule

// ==== smsp_slave_model.sv ====
// Purpose: Far-end serial slave for master-role transfers.
// Assumes: Clock edges are seen at the falling core clock edge.
// Notes: The data line toggles while not selected.
`timescale 1ns/1ps
module smsp_slave_model (
  input wire i_clk,
  input wire i_sck,
  input wire i_mosi,
  input wire i_sel_n,
  input wire i_clock_polarity,
  input wire i_clock_phase,
  input wire [7:0] i_tx,
  output reg o_miso,
  output reg [7:0] o_rx
);
  reg [7:0] sh = 8'h00;
  reg pk = 1'b0;
  reg pl = 1'b1;
  initial o_miso = 1'b0;
  initial o_rx = 8'h00;
  always @(negedge i_clk) begin
    pk <= i_sck;
    pl <= i_sel_n;
    if (i_sel_n) begin
      o_miso <= ~o_miso;
    end else if (pl) begin
      o_miso <= i_tx[7];
      sh <= i_clock_phase ? i_tx : {i_tx[6:0], 1'b0};
    end else if (i_sck !== pk) begin
      if ((i_sck !== i_clock_polarity) ^ i_clock_phase) begin
        o_rx <= {o_rx[6:0], i_mosi};
      end else begin
        o_miso <= sh[7];
        sh <= {sh[6:0], 1'b0};
      end
    end
  end
endmodule

// ==== smsp_port_assertions.sv ====
// Purpose: Port-level checks of the serial port.
// Assumes: Bound to the port module.
// Notes: Select latency is taken as at most eight cycles, deselect latency as at most six.
`timescale 1ns/1ps
module smsp_chk (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_ss_n,
  input wire o_ss_n_oe,
  input wire o_sck_oe,
  input wire o_mosi_oe,
  input wire o_miso_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_rans;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  sequence s_ss_in_low;
    (!i_ss_n && !o_ss_n_oe) [*8];
  endsequence
  sequence s_ss_high;
    i_ss_n [*6];
  endsequence
  a_wait_answer: assert property (s_req |=> !o_avs_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer too long");
  a_wait_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> o_avs_waitrequest) else $error("answer without request");
  a_read_upper: assert property (s_rans |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_stat_reserved: assert property (s_rans ##0 (i_avs_address == 4'h4)
    |-> o_avs_readdata[5:1] == 5'h00) else $error("reserved status bits set");
  a_unmapped_zero: assert property (s_rans ##0 (i_avs_address[1:0] != 2'h0)
    |-> o_avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  a_miso_released: assert property (s_ss_high |-> !o_miso_oe)
    else $error("data out driven while deselected");
  a_master_yields: assert property (s_ss_in_low |-> !o_sck_oe && !o_mosi_oe)
    else $error("clock or data out driven under select");
endmodule
bind smsp_port smsp_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_ss_n(i_ss_n), .o_ss_n_oe(o_ss_n_oe), .o_sck_oe(o_sck_oe), .o_mosi_oe(o_mosi_oe),
  .o_miso_oe(o_miso_oe));

// ==== test_smsp_port.sv ====
// Purpose: Self-checking bench for the serial port.
// Assumes: Pins resolve from output enables.
// Notes: Bench drives clock and data when the port is a slave.
`timescale 1ns/1ps
module test_smsp_port;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg rd = 1'b0, wr = 1'b0, ts = 1'b0, tm = 1'b0, tss = 1'b1;
  reg mcpol = 1'b0, mcpha = 1'b0, ps = 1'b0;
  reg [3:0] a = 4'h0;
  reg [31:0] wd = 32'h00000000;
  reg [7:0] mtx = 8'h00, q = 8'h00, half = 8'h00, hc = 8'h00;
  integer n_errors = 0, total_checks = 0, i;
  wire [31:0] rdat;
  wire [7:0] mrx;
  wire wait_r, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, ss, ss_oe, irq, mmiso;
  wire w_sck = sck_oe ? sck : ts;
  wire w_mosi = mosi_oe ? mosi : tm;
  wire w_miso = miso_oe ? miso : mmiso;
  wire w_ss = ss_oe ? ss : tss;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    ps <= sck;
    if (sck !== ps) begin
      half <= hc;
      hc <= 8'h01;
    end else begin
      hc <= hc + 8'h01;
    end
  end
  smsp_port u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(a), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .i_sck(w_sck), .o_sck(sck), .o_sck_oe(sck_oe),
    .i_mosi(w_mosi), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .i_miso(w_miso), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_ss_n(w_ss), .o_ss_n(ss), .o_ss_n_oe(ss_oe), .o_irq(irq));
  smsp_slave_model u_mdl (.i_clk(clk), .i_sck(sck), .i_mosi(mosi), .i_sel_n(ss_oe ? ss : 1'b1),
    .i_clock_polarity(mcpol), .i_clock_phase(mcpha), .i_tx(mtx), .o_miso(mmiso), .o_rx(mrx));
  function [7:0] rev(input [7:0] v);
    integer j;
    for (j = 0; j < 8; j = j + 1) rev[j] = v[7 - j];
  endfunction
  function [7:0] hexp(input [1:0] r, input d);
    hexp = (d ? 8'h01 : 8'h02) << (r == 2'h3 ? 3'h5 : {r, 1'b0});
  endfunction
  task final_report;
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task guard(input integer k);
    if (k > 700) begin
      n_errors = n_errors + 1;
      final_report;
    end
  endtask
  task bus(input w, input [3:0] ad, input [7:0] d);
    integer k;
    k = 0;
    a <= ad;
    wd <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wait_r !== 1'b0) begin
      k = k + 1;
      guard(k);
      @(posedge clk);
    end
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input [3:0] ad, input [7:0] e);
    bus(1'b0, ad, 8'h00);
    chk(q, e);
  endtask
  task wait_done;
    integer k;
    k = 0;
    q = 8'h00;
    while (q[7] !== 1'b1) begin
      k = k + 1;
      guard(k);
      bus(1'b0, 4'h4, 8'h00);
    end
  endtask
  task cfg(input [7:0] c, input dbl);
    mcpol <= c[3];
    mcpha <= c[2];
    bus(1'b1, 4'h0, c);
    bus(1'b1, 4'h4, {7'h00, dbl});
    bus(1'b1, 4'hC, 8'h37);
    bus(1'b1, 4'hC, 8'h33);
  endtask
  task t_master(input [7:0] c, input dbl, input [7:0] tx, input [7:0] sv);
    mtx <= sv;
    cfg(c, dbl);
    bus(1'b1, 4'h8, tx);
    wait_done;
    chk({7'h00, irq}, {7'h00, c[7]});
    chk(half, hexp(c[1:0], dbl));
    rdc(4'h8, c[5] ? rev(sv) : sv);
    chk(mrx, c[5] ? rev(tx) : tx);
    rdc(4'h4, {7'h00, dbl});
  endtask
  task t_coll;
    mtx <= 8'h66;
    cfg(8'h50, 1'b0);
    bus(1'b1, 4'h8, 8'h81);
    bus(1'b1, 4'h8, 8'h7E);
    wait_done;
    chk(q, 8'hC0);
    rdc(4'h8, 8'h66);
    chk(mrx, 8'h81);
    rdc(4'h4, 8'h00);
  endtask
  task t_force;
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'hC, 8'h31);
    bus(1'b1, 4'h0, 8'hD0);
    rdc(4'h4, 8'h00);
    tss <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h00, sck_oe}, 8'h00);
    rdc(4'h0, 8'hC0);
    chk({7'h00, irq}, 8'h01);
    rdc(4'h4, 8'h80);
    tss <= 1'b1;
    bus(1'b0, 4'h8, 8'h00);
    rdc(4'h4, 8'h00);
    bus(1'b1, 4'h0, 8'hD0);
    rdc(4'h0, 8'hD0);
    chk({7'h00, sck_oe}, 8'h01);
  endtask
  task frame(input [7:0] v, input integer n);
    integer j;
    tss <= 1'b0;
    repeat (6) @(posedge clk);
    for (j = 0; j < n; j = j + 1) begin
      tm <= v[7 - j];
      repeat (4) @(posedge clk);
      q = {q[6:0], w_miso};
      ts <= 1'b1;
      repeat (4) @(posedge clk);
      ts <= 1'b0;
    end
    repeat (6) @(posedge clk);
    tss <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task t_slave;
    bus(1'b1, 4'h0, 8'h43);
    bus(1'b1, 4'hC, 8'h08);
    frame(8'hFF, 3);
    bus(1'b1, 4'h8, 8'h3C);
    frame(8'hA5, 8);
    chk(q, 8'h3C);
    rdc(4'h4, 8'h80);
    rdc(4'h8, 8'hA5);
    rdc(4'h4, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(4'h0, 8'h00);
    rdc(4'h4, 8'h00);
    rdc(4'h2, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      t_master({i[0], 1'b1, i[2] ^ i[0], 1'b1, i[1:0], i[1:0]}, i[2],
        8'hA3 + i[7:0], 8'h5C ^ i[7:0]);
    end
    t_coll;
    t_force;
    t_slave;
    final_report;
  end
endmodule
